// >>> hdl/gpp_defines.svh
// constants for the general-purpose port block: offsets, field positions, reset values
`ifndef GPP_DEFINES_SVH
`define GPP_DEFINES_SVH

// data-memory addresses of the port block registers
`define GPP_ADDR_DISP_CTRL 7'h6a
`define GPP_ADDR_PORT_A 7'h70
`define GPP_ADDR_PORT_B 7'h71
`define GPP_ADDR_PORT_C 7'h72
`define GPP_ADDR_PORT_D 7'h73

// field positions in the display-enable control register
`define GPP_BIT_DIR0 0
`define GPP_BIT_DIR1 1
`define GPP_BIT_TONE 2
`define GPP_BIT_DISP 3

// field positions in the port registers
`define GPP_BIT_TONE_PIN 0
`define GPP_BIT_PB_PAD 3

// reset values
`define GPP_NIBBLE_ZERO 4'h0
`define GPP_DIR_INPUT 2'h0

`endif

// >>> hdl/gpp_pkg.sv
// types shared by the general-purpose port block
package gpp_pkg;

   // data-memory access from the core, one word per cycle
   typedef struct packed {
      logic wr;          // write strobe
      logic rd;          // read strobe
      logic [6:0] addr;  // data-memory address
      logic [3:0] wdata; // write nibble
   } gpp_mem_req_t;

   // both two-way pins as seen at the module boundary
   typedef struct packed {
      logic [1:0] out; // driven level
      logic [1:0] oe;  // high while driving
   } gpp_bidir_drv_t;

   // core-side reset and power state indications
   typedef struct packed {
      logic ce_reset;   // chip-enable reset pulse or level
      logic clock_stop; // oscillator stopped
      logic halt;       // core halted
   } gpp_power_t;

endpackage : gpp_pkg

// >>> hdl/gpp_ports.sv
// general-purpose port block: two-way, input-only and output-only pins behind data memory
//
// Contract
// - each two-way pin has own direction flag
// - flag 0 selects input, 1 selects output
// - input-mode two-way pin is not driven
// - input-mode pin reads its pin level
// - port a write updates latch in input mode
// - output-mode pin drives its latch bit
// - write 1 drives high, 0 drives low
// - output-mode read returns actual pin level
// - power-on: input mode, latches cleared
// - ce reset, clock stop: input, latches kept
// - halt keeps directions and latches
// - port b reads three inputs, bit3 zero
// - port b write changes nothing
// - port d bit0 pin, tone when selected
// - output-only pins drive their latches
// - input-only pins pulled down, float reads 0
`timescale 1ns/1ps
`include "gpp_defines.svh"

module gpp_ports
   import gpp_pkg::*;
#(
   parameter int NUM_BIDIR = 2, // two-way pins on port a
   parameter int NUM_IN = 3     // input-only pins on port b
) (
   // clock and power-on reset
   input wire logic clk_i,
   input wire logic reset_i,
   // core data-memory access
   input wire gpp_mem_req_t mem_req_i,
   output logic [3:0] rdata_o,
   output logic rvalid_o,
   // core power state
   input wire gpp_power_t power_i,
   // tone source from the beep generator, same clock
   input wire logic tone_i,
   // port a two-way pins
   input wire logic [NUM_BIDIR-1:0] bidir_pin_i,
   output logic [NUM_BIDIR-1:0] bidir_pin_o,
   output logic [NUM_BIDIR-1:0] bidir_pin_oe_o,
   // port a output-only pins
   output logic [1:0] port_a_out_o,
   // port b input-only pins
   input wire logic [NUM_IN-1:0] port_b_pin_i,
   // port c output-only pins
   output logic [3:0] port_c_o,
   // port d tone-capable output pin
   output logic tone_capable_out_pin_o,
   // display enable flag toward the display driver
   output logic display_enable_flag_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // decode helpers

   // true when the access writes the given address
   function automatic logic wr_hit(input gpp_mem_req_t req, input logic [6:0] target);
      wr_hit = req.wr && (req.addr == target);
   endfunction : wr_hit

   // true when a write may land: not halted, not forced by ce reset or clock stop
   function automatic logic wr_allowed(input gpp_power_t pw);
      wr_allowed = !pw.halt && !pw.ce_reset && !pw.clock_stop;
   endfunction : wr_allowed

   ////////////////////////////////////////////////////////////////////////////////
   // state

   logic [3:0] display_enable_ctrl; // direction, tone and display flags
   logic [3:0] port_a_bits;         // port a output latch
   logic [3:0] port_c_outputs;      // port c output latch
   logic port_d_output;             // port d bit 0 latch, bits 1-3 read zero
   logic [NUM_BIDIR-1:0] bidir_level; // settled two-way pin levels
   logic [NUM_IN-1:0] port_b_inputs;  // settled input-only pin levels
   logic [NUM_BIDIR+NUM_IN-1:0] sync_level; // synchroniser output
   logic [3:0] next_rdata; // read mux result
   logic force_input;      // ce reset or clock stop in progress

   assign force_input = power_i.ce_reset || power_i.clock_stop;

   ////////////////////////////////////////////////////////////////////////////////
   // pin input synchronisers

   // two-way and input-only pins share one synchroniser
   gpp_sync #(
      .WIDTH(NUM_BIDIR + NUM_IN)
   ) u_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .async_i({port_b_pin_i, bidir_pin_i}),
      .level_o(sync_level)
   );

   // split settled levels; undriven port b pins are pulled down outside, so read 0
   assign bidir_level = sync_level[NUM_BIDIR-1:0];
   assign port_b_inputs = sync_level[NUM_BIDIR+NUM_IN-1:NUM_BIDIR];

   ////////////////////////////////////////////////////////////////////////////////
   // display-enable control register

   // direction flags: cleared on power-on, forced to input on ce reset or clock stop
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         display_enable_ctrl <= `GPP_NIBBLE_ZERO;
      end else if (force_input) begin
         // only directions are forced; the other flags hold
         display_enable_ctrl[`GPP_BIT_DIR1:`GPP_BIT_DIR0] <= `GPP_DIR_INPUT;
      end else if (power_i.halt) begin
         // halted: everything stays as it was
         display_enable_ctrl <= display_enable_ctrl;
      end else if (wr_hit(mem_req_i, `GPP_ADDR_DISP_CTRL)) begin
         display_enable_ctrl <= mem_req_i.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // output latches

   // port a latch: written whatever the pin direction, kept over ce reset
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         port_a_bits <= `GPP_NIBBLE_ZERO;
      end else if (wr_allowed(power_i) && wr_hit(mem_req_i, `GPP_ADDR_PORT_A)) begin
         port_a_bits <= mem_req_i.wdata;
      end
   end

   // port c latch
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         port_c_outputs <= `GPP_NIBBLE_ZERO;
      end else if (wr_allowed(power_i) && wr_hit(mem_req_i, `GPP_ADDR_PORT_C)) begin
         port_c_outputs <= mem_req_i.wdata;
      end
   end

   // port d latch, bit 0 only
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         port_d_output <= 1'b0;
      end else if (wr_allowed(power_i) && wr_hit(mem_req_i, `GPP_ADDR_PORT_D)) begin
         port_d_output <= mem_req_i.wdata[`GPP_BIT_TONE_PIN];
      end
   end

   // port b has no storage; a write there is simply dropped

   ////////////////////////////////////////////////////////////////////////////////
   // pin drivers, all straight from flip-flops

   // two-way pins: drive latch when flag is 1, float when flag is 0
   assign bidir_pin_o = port_a_bits[NUM_BIDIR-1:0];
   assign bidir_pin_oe_o = display_enable_ctrl[`GPP_BIT_DIR1:`GPP_BIT_DIR0];

   // output-only pins follow their latches
   assign port_a_out_o = port_a_bits[3:2];
   assign port_c_o = port_c_outputs;
   assign display_enable_flag_o = display_enable_ctrl[`GPP_BIT_DISP];

   // tone pin: registered mux so the pin comes from a flip-flop
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         tone_capable_out_pin_o <= 1'b0;
      end else if (display_enable_ctrl[`GPP_BIT_TONE]) begin
         tone_capable_out_pin_o <= tone_i;
      end else begin
         tone_capable_out_pin_o <= port_d_output;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read path

   // read mux: port a shows real pin levels for the two-way bits
   always_comb begin
      next_rdata = `GPP_NIBBLE_ZERO;
      unique case (mem_req_i.addr)
         `GPP_ADDR_DISP_CTRL: begin
            next_rdata = display_enable_ctrl;
         end
         `GPP_ADDR_PORT_A: begin
            // pin level in both directions, latch for output-only bits
            next_rdata = {port_a_bits[3:2], bidir_level};
         end
         `GPP_ADDR_PORT_B: begin
            // bit 3 has no pin and reads 0
            next_rdata = {1'b0, port_b_inputs};
         end
         `GPP_ADDR_PORT_C: begin
            next_rdata = port_c_outputs;
         end
         `GPP_ADDR_PORT_D: begin
            next_rdata = {3'h0, tone_capable_out_pin_o};
         end
         default: begin
            // unmapped address reads zero
            next_rdata = `GPP_NIBBLE_ZERO;
         end
      endcase
   end

   // read data register, answered the cycle after the strobe
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_o <= `GPP_NIBBLE_ZERO;
      end else if (mem_req_i.rd) begin
         rdata_o <= next_rdata;
      end
   end

   // read valid pulse
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rvalid_o <= 1'b0;
      end else begin
         rvalid_o <= mem_req_i.rd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   // a direction write lands on the pin enables next cycle
   property p_dir_write;
      (wr_hit(mem_req_i, `GPP_ADDR_DISP_CTRL) && wr_allowed(power_i))
         |=> (bidir_pin_oe_o == $past(mem_req_i.wdata[1:0]));
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("direction flags did not follow the write");

   // pin 0 enable is low whenever its flag is 0; flag 0 leaves the pin undriven
   property p_dir_sense;
      (display_enable_ctrl[`GPP_BIT_DIR0] == 1'b0) |-> !bidir_pin_oe_o[0];
   endproperty
   a_dir_sense: assert property (p_dir_sense)
      else $error("pin 0 driven while in input mode");

   // port a write updates the latch even with both pins in input mode
   property p_latch_in_input;
      (wr_hit(mem_req_i, `GPP_ADDR_PORT_A) && wr_allowed(power_i) && (bidir_pin_oe_o == 2'h0))
         |=> (bidir_pin_o == $past(mem_req_i.wdata[1:0])) && (port_a_out_o == $past(mem_req_i.wdata[3:2]));
   endproperty
   a_latch_in_input: assert property (p_latch_in_input)
      else $error("port a latch missed a write in input mode");

   // ce reset or clock stop forces input mode and keeps the latches
   property p_force_input;
      force_input |=> (bidir_pin_oe_o == 2'h0) && $stable(bidir_pin_o) && $stable(port_c_o);
   endproperty
   a_force_input: assert property (p_force_input)
      else $error("forced input mode lost a latch or left a pin driven");

   // halt keeps directions and latches for as long as it lasts
   property p_halt_hold;
      (power_i.halt && !force_input)
         |=> $stable(bidir_pin_oe_o) && $stable(bidir_pin_o) && $stable(port_c_o) && $stable(port_a_out_o);
   endproperty
   a_halt_hold: assert property (p_halt_hold)
      else $error("state changed during halt");

   // port b read returns the settled pin levels with bit 3 zero
   property p_port_b_read;
      (mem_req_i.rd && (mem_req_i.addr == `GPP_ADDR_PORT_B))
         |=> (rdata_o == {1'b0, $past(port_b_inputs)});
   endproperty
   a_port_b_read: assert property (p_port_b_read)
      else $error("port b read value wrong");

   // a port b write disturbs nothing
   property p_port_b_write;
      wr_hit(mem_req_i, `GPP_ADDR_PORT_B) && !force_input
         |=> $stable(bidir_pin_oe_o) && $stable(bidir_pin_o) && $stable(port_c_o) && $stable(tone_capable_out_pin_o)
             || $past(display_enable_ctrl[`GPP_BIT_TONE]);
   endproperty
   a_port_b_write: assert property (p_port_b_write)
      else $error("port b write changed state");

   // port a read returns the real two-way pin levels, not the latch
   property p_port_a_read;
      (mem_req_i.rd && (mem_req_i.addr == `GPP_ADDR_PORT_A))
         |=> (rdata_o[1:0] == $past(bidir_level));
   endproperty
   a_port_a_read: assert property (p_port_a_read)
      else $error("port a read did not show pin level");

   // tone pin carries the tone when selected; the latch case is left to a_port_d_latch
   property p_tone_mux;
      display_enable_ctrl[`GPP_BIT_TONE] |=> (tone_capable_out_pin_o == $past(tone_i));
   endproperty
   a_tone_mux: assert property (p_tone_mux)
      else $error("tone pin does not carry the tone");

   // every read is answered exactly one cycle later
   property p_read_timing;
      mem_req_i.rd |=> rvalid_o ##1 (rvalid_o == $past(mem_req_i.rd));
   endproperty
   a_read_timing: assert property (p_read_timing)
      else $error("read answer not one cycle after strobe");

   // a port a write lands on all four pins next cycle
   property p_port_a_write;
      (wr_hit(mem_req_i, `GPP_ADDR_PORT_A) && wr_allowed(power_i))
         |=> ({port_a_out_o, bidir_pin_o} == $past(mem_req_i.wdata));
   endproperty
   a_port_a_write: assert property (p_port_a_write)
      else $error("port a pins did not follow the write");

   // a port c write lands on its four pins next cycle
   property p_port_c_write;
      (wr_hit(mem_req_i, `GPP_ADDR_PORT_C) && wr_allowed(power_i))
         |=> (port_c_o == $past(mem_req_i.wdata));
   endproperty
   a_port_c_write: assert property (p_port_c_write)
      else $error("port c pins did not follow the write");

   // with the tone off, the port d pin shows the written bit two cycles on
   property p_port_d_latch;
      (wr_hit(mem_req_i, `GPP_ADDR_PORT_D) && wr_allowed(power_i)) ##1 !display_enable_ctrl[`GPP_BIT_TONE]
         |=> (tone_capable_out_pin_o == $past(mem_req_i.wdata[`GPP_BIT_TONE_PIN], 2));
   endproperty
   a_port_d_latch: assert property (p_port_d_latch)
      else $error("port d pin does not carry its latch");

   // a write while halted, in ce reset or in clock stop leaves the port a and port c latches alone
   property p_write_blocked;
      (mem_req_i.wr && !wr_allowed(power_i))
         |=> $stable(bidir_pin_o) && $stable(port_a_out_o) && $stable(port_c_o);
   endproperty
   a_write_blocked: assert property (p_write_blocked)
      else $error("blocked write changed a latch");

   // a control register read returns the flags as they stood at the strobe
   property p_ctrl_read;
      (mem_req_i.rd && (mem_req_i.addr == `GPP_ADDR_DISP_CTRL))
         |=> (rdata_o == $past(display_enable_ctrl));
   endproperty
   a_ctrl_read: assert property (p_ctrl_read)
      else $error("control register read value wrong");

   // main scenarios
   c_pin_output: cover property (wr_hit(mem_req_i, `GPP_ADDR_DISP_CTRL) ##1 (bidir_pin_oe_o == 2'h3));
   c_ce_reset: cover property ((bidir_pin_oe_o != 2'h0) ##1 power_i.ce_reset ##1 (bidir_pin_oe_o == 2'h0));
   c_tone_on: cover property (display_enable_ctrl[`GPP_BIT_TONE] && tone_i);
   c_port_b_read: cover property (mem_req_i.rd && (mem_req_i.addr == `GPP_ADDR_PORT_B));

endmodule : gpp_ports

// >>> hdl/gpp_sync.sv
// three-stage input synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps

module gpp_sync #(
   parameter int WIDTH = 5
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // asynchronous pins in, settled levels out
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] level_o
);

   logic [WIDTH-1:0] stage1; // metastability catcher, read only by stage2
   logic [WIDTH-1:0] stage2; // second stage
   logic [WIDTH-1:0] stage3; // third stage

   // shift chain; the first stage feeds nothing but the second
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // a change counts only once stages two and three agree, per bit
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_agree
         always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
               level_o[g] <= 1'b0;
            end else if (stage2[g] == stage3[g]) begin
               level_o[g] <= stage3[g];
            end
         end
      end
   endgenerate

endmodule : gpp_sync

// >>> test/general_purpose_ports_tb.sv
// self-checking bench for the general-purpose port block
`timescale 1ns/1ps
`include "gpp_defines.svh"

module general_purpose_ports_tb
   import gpp_pkg::*;
;

   // one ordinary case: register writes, outside drive, expected reads
   typedef struct packed {
      logic [3:0] ctrl, pa, pc;
      logic [1:0] ee, ev;
      logic [2:0] be, bv;
      logic [3:0] xa;
      logic [2:0] xb;
   } gpp_row_t;

   logic clk_i, reset_i, tone, rvalid, tone_pin, disp;
   gpp_mem_req_t mem_req; // core request
   gpp_power_t power; // power state
   logic [3:0] rdata, pc;
   logic [1:0] wire_ab, pin_o, oe, pa_out, ext_en, ext_val;
   logic [2:0] pb_wire, pb_en, pb_val;
   int n_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   gpp_row_t rows [5] = '{
      '{4'h0, 4'hf, 4'ha, 2'h3, 2'h2, 3'h7, 3'h5, 4'he, 3'h5},
      '{4'h3, 4'h1, 4'h5, 2'h0, 2'h0, 3'h0, 3'h0, 4'h1, 3'h0},
      '{4'h9, 4'h6, 4'hf, 2'h2, 2'h2, 3'h3, 3'h2, 4'h6, 3'h2},
      '{4'ha, 4'hb, 4'h0, 2'h1, 2'h1, 3'h7, 3'h7, 4'hb, 3'h7},
      '{4'h3, 4'h3, 4'h3, 2'h1, 2'h0, 3'h4, 3'h4, 4'h2, 3'h4}};

   gpp_ports gpp_ports_i (.clk_i(clk_i), .reset_i(reset_i), .mem_req_i(mem_req), .rdata_o(rdata),
      .rvalid_o(rvalid), .power_i(power), .tone_i(tone), .bidir_pin_i(wire_ab), .bidir_pin_o(pin_o),
      .bidir_pin_oe_o(oe), .port_a_out_o(pa_out), .port_b_pin_i(pb_wire), .port_c_o(pc),
      .tone_capable_out_pin_o(tone_pin), .display_enable_flag_o(disp));
   gpp_pins_model gpp_pins_model_i (.dev_out_i(pin_o), .dev_oe_i(oe), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .pb_en_i(pb_en), .pb_val_i(pb_val), .bidir_wire_o(wire_ab),
      .port_b_wire_o(pb_wire));

   ////////////////////////////////////////////////////////////////////////////////
   // clock and hang limit
   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         $display("MISMATCH at %0t: run did not finish", $time);
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // comparison, bus cycles and verdict
   task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [6:0] a, input logic [3:0] d);
      @(negedge clk_i);
      mem_req.wr = 1'b1;
      mem_req.addr = a;
      mem_req.wdata = d;
      @(negedge clk_i);
      mem_req.wr = 1'b0;
   endtask : wr

   // read: answer is valid exactly one cycle after the request
   task automatic rdc(input logic [6:0] a, input logic [3:0] exp);
      @(negedge clk_i);
      mem_req.rd = 1'b1;
      mem_req.addr = a;
      @(negedge clk_i);
      mem_req.rd = 1'b0;
      chk({3'h0, rvalid}, 4'h1, "read valid");
      chk(rdata, exp, "read data");
   endtask : rdc

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      clk_i = 1'b0;
      reset_i = 1'b1;
      mem_req = '0;
      power = '0;
      tone = 1'b0;
      {ext_en, ext_val, pb_en, pb_val} = '0;
      repeat (3) @(negedge clk_i);
      reset_i = 1'b0;
      chk({oe, pin_o}, 4'h0, "power-on pins");
      chk({pa_out, tone_pin, disp}, 4'h0, "power-on outputs");
      chk(pc, 4'h0, "power-on port c");
      // table of ordinary cases
      foreach (rows[k]) begin
         {ext_en, ext_val, pb_en, pb_val} = {rows[k].ee, rows[k].ev, rows[k].be, rows[k].bv};
         wr(`GPP_ADDR_DISP_CTRL, rows[k].ctrl);
         wr(`GPP_ADDR_PORT_A, rows[k].pa);
         wr(`GPP_ADDR_PORT_C, rows[k].pc);
         repeat (6) @(negedge clk_i);
         chk({oe, pin_o}, {rows[k].ctrl[1:0], rows[k].pa[1:0]}, "dir and drive");
         chk({pa_out, 1'b0, disp}, {rows[k].pa[3:2], 1'b0, rows[k].ctrl[3]}, "port a out");
         chk(pc, rows[k].pc, "port c pins");
         rdc(`GPP_ADDR_PORT_A, rows[k].xa);
         rdc(`GPP_ADDR_PORT_B, {1'b0, rows[k].xb});
         rdc(`GPP_ADDR_PORT_C, rows[k].pc);
         rdc(`GPP_ADDR_DISP_CTRL, rows[k].ctrl);
      end
      // input-only register ignores writes; unmapped place reads 0
      wr(`GPP_ADDR_PORT_B, 4'hf);
      rdc(`GPP_ADDR_PORT_B, 4'h4);
      wr(7'h10, 4'hf);
      rdc(7'h10, 4'h0);
      chk(pc, 4'h3, "port c after stray writes");
      wr(`GPP_ADDR_DISP_CTRL, 4'h0);
      ext_en = 2'h0; // outside drivers let go only once both pins are inputs
      // port d latch and tone selection
      wr(`GPP_ADDR_PORT_D, 4'hf);
      @(negedge clk_i);
      chk({3'h0, tone_pin}, 4'h1, "port d pin");
      rdc(`GPP_ADDR_PORT_D, 4'h1);
      wr(`GPP_ADDR_PORT_D, 4'h0);
      wr(`GPP_ADDR_DISP_CTRL, 4'h4);
      tone = 1'b1;
      @(negedge clk_i);
      chk({3'h0, tone_pin}, 4'h1, "tone high");
      tone = 1'b0;
      @(negedge clk_i);
      chk({3'h0, tone_pin}, 4'h0, "tone low");
      // chip-enable reset, then clock stop: inputs forced, latches kept, writes dropped
      for (int j = 0; j < 2; j++) begin
         wr(`GPP_ADDR_DISP_CTRL, 4'hb);
         wr(`GPP_ADDR_PORT_A, 4'h3);
         power.ce_reset = (j == 0);
         power.clock_stop = (j == 1);
         @(negedge clk_i);
         chk({oe, pin_o}, 4'h3, "forced input");
         chk({3'h0, disp}, 4'h1, "display flag kept");
         wr(`GPP_ADDR_PORT_A, 4'h0);
         power = '0;
         wr(`GPP_ADDR_DISP_CTRL, 4'h3);
         chk({oe, pin_o}, 4'hf, "latch kept");
      end
      // halt freezes directions and latches
      power.halt = 1'b1;
      wr(`GPP_ADDR_DISP_CTRL, 4'h0);
      wr(`GPP_ADDR_PORT_A, 4'h0);
      repeat (4) @(negedge clk_i);
      chk({oe, pin_o}, 4'hf, "halt hold");
      power.halt = 1'b0;
      // power-on reset in mid-run clears latches too
      reset_i = 1'b1;
      @(negedge clk_i);
      chk({oe, pin_o}, 4'h0, "mid-run reset");
      reset_i = 1'b0;
      wr(`GPP_ADDR_DISP_CTRL, 4'h3);
      chk({oe, pin_o}, 4'hc, "latch cleared");
      complete_run();
   end
endmodule : general_purpose_ports_tb

// >>> test/gpp_pins_model.sv
// outside circuits on the port pins: drivers and loads for the two-way and input-only pins
`timescale 1ns/1ps

module gpp_pins_model (
   // device side of the two-way pins
   input wire logic [1:0] dev_out_i,
   input wire logic [1:0] dev_oe_i,
   // drive commands from the bench
   input wire logic [1:0] ext_en_i,
   input wire logic [1:0] ext_val_i,
   input wire logic [2:0] pb_en_i,
   input wire logic [2:0] pb_val_i,
   // resolved wire levels
   output logic [1:0] bidir_wire_o,
   output logic [2:0] port_b_wire_o
);
   logic [1:0] last_level = 2'h0; // level each two-way wire last carried under drive

   ////////////////////////////////////////////////////////////////////////////////
   // two-way wires: a low outside load beats the device, a free wire shows no stale value
   always @(dev_out_i, dev_oe_i, ext_en_i, ext_val_i) begin
      for (int i = 0; i < 2; i++) begin
         if (dev_oe_i[i] && ext_en_i[i]) begin
            last_level[i] = dev_out_i[i] & ext_val_i[i];
         end else if (dev_oe_i[i]) begin
            last_level[i] = dev_out_i[i];
         end else if (ext_en_i[i]) begin
            last_level[i] = ext_val_i[i];
         end
         // a released wire has no pull, so it shows the opposite of its last driven level
         bidir_wire_o[i] = (dev_oe_i[i] || ext_en_i[i]) ? last_level[i] : ~last_level[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // input-only wires: outside pull-down takes a released pin low
   assign port_b_wire_o = pb_en_i & pb_val_i;
endmodule : gpp_pins_model
